// *** wdsr_regs.svh ***
// register offsets, field positions, reset values and timing counts of the watchdog block
// assumes: included by bare name wherever one of these numbers is needed
`ifndef WDSR_REGS_SVH
`define WDSR_REGS_SVH

// ****************************************************************
// register offsets on the plain port
// ****************************************************************
`define WDSR_OFF_OPTION        2'h0
`define WDSR_OFF_STATUS        2'h1
`define WDSR_OFF_CONFIG        2'h2

// ****************************************************************
// field positions
// ****************************************************************
`define WDSR_OPT_PIN_WAKE_EN_N 7
`define WDSR_OPT_PRESC_ASSIGN  3
`define WDSR_OPT_PS_MSB        2
`define WDSR_OPT_PS_LSB        0
`define WDSR_ST_PIN_WAKE       7
`define WDSR_ST_CMP_WAKE       6
`define WDSR_ST_TIMEOUT_N      4
`define WDSR_ST_POWERDOWN_N    3
`define WDSR_CFG_WDT_EN        0
`define WDSR_CFG_EXT_RST_EN    1
`define WDSR_CFG_CMP_WAKE_EN   2

// ****************************************************************
// reset values
// ****************************************************************
`define WDSR_OPTION_RST        8'hFF
`define WDSR_CONFIG_RST        3'h3

// ****************************************************************
// timing: base period in microseconds, one oscillator tick in ns
// ****************************************************************
`define WDSR_WDT_PERIOD_US     18000
`define WDSR_OSC_TICK_NS       1000
`define WDSR_WDT_BASE_TICKS    ((`WDSR_WDT_PERIOD_US * 1000) / `WDSR_OSC_TICK_NS)

`endif

// *** wdsr_pkg.sv ***
// types shared by the watchdog, sleep and reset-cause block
// assumes: numbers live in wdsr_regs.svh, this package holds types only
package wdsr_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    // power mode of the core as seen by this block
    typedef enum logic {
        WDSR_AWAKE,
        WDSR_ASLEEP
    } wdsr_mode_e;

    typedef logic [7:0] wdsr_byte_t;

    // whole state of the top module
    typedef struct packed {
        wdsr_byte_t option;     // prescaler and wake options
        logic [2:0] cfg;        // configuration bits
        wdsr_mode_e mode;       // awake or asleep
        logic       to_n;       // time-out flag, low after a time-out
        logic       pd_n;       // power-down flag, low after sleep
        logic       pin_wake;   // woke on pin change
        logic       cmp_wake;   // woke on comparator change
        logic       dev_reset;  // one-cycle device reset pulse
        wdsr_byte_t rdata;      // read data of the plain port
        logic       ext_oe_n;   // reset pin output enable, never driven
    } wdsr_state_s;

endpackage

// *** wdsr_tick_counter.sv ***
// clearable tick counter with a terminal value and a one-cycle done pulse
// assumes: one clock, inc and clr synchronous, ce freezes the count
`timescale 1ns/1ps
`default_nettype none

module wdsr_tick_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // control
    input  wire logic         clr,
    input  wire logic         inc,
    input  wire logic [W-1:0] terminal,
    // status
    output logic              done,
    output logic [W-1:0]      count
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [W-1:0] cnt;  // ticks seen since last clear
        logic         done; // wrapped at terminal last cycle
    } wdsr_cnt_s;

    wdsr_cnt_s q;
    wdsr_cnt_s d;

    // clear beats increment so a clear never lets a stale wrap through
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (clr) begin
            d.cnt = '0;
        end else if (inc) begin
            if (q.cnt == terminal) begin
                d.cnt  = '0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    // register the whole state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign done  = q.done;
    assign count = q.cnt;

    a_clear_zeroes: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && clr |=> count == '0 && !done) else $error("counter not cleared");
    a_wrap_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && inc && !clr && count == terminal |=> done && count == '0)
        else $error("no done pulse at terminal");

endmodule

`default_nettype wire

// *** wdsr_change_det.sv ***
// change detector: flags when a value differs from the reference last captured
// assumes: capture is a synchronous pulse, ce freezes the state
`timescale 1ns/1ps
`default_nettype none

module wdsr_change_det #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // watched value
    input  wire logic         capture,
    input  wire logic [W-1:0] value,
    // result
    output logic              changed
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [W-1:0] ref_v;   // reference level
        logic         changed; // differs from reference
    } wdsr_chg_s;

    wdsr_chg_s q;
    wdsr_chg_s d;

    // a capture re-arms; otherwise the mismatch stays up as long as it lasts
    always_comb begin
        d = q;
        if (capture) begin
            d.ref_v   = value;
            d.changed = 1'b0;
        end else begin
            d.changed = (value != q.ref_v);
        end
    end

    // register the whole state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign changed = q.changed;

    a_capture_rearm: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && capture |=> !changed) else $error("change seen right after capture");

endmodule

`default_nettype wire

// *** wdsr_watchdog.sv ***
// watchdog timer with prescaler, sleep entry and wake, and reset-cause flags
// assumes: one clock mclk; core strobes and pins synchronous to it; the
// watchdog oscillator arrives as a one-cycle tick pulse wdt_osc_tick
//
// How it works
// - watchdog counts ticks of its own oscillator
// - watchdog time-out always resets the device
// - time-out reset clears the time-out flag
// - configuration enable low keeps watchdog silent
// - unscaled time-out after the base period
// - prescaler stretches time-out up to 1:128
// - clear-watchdog clears counter and assigned prescaler
// - sleep clears counter and assigned prescaler
// - sleep sets time-out flag, clears power-down flag
// - pins hold their drive state while asleep
// - watchdog reset never drives reset pin
// - four events wake the device through reset
// - watchdog wake flags per sleep state
// - external reset flags per sleep state
// - pin wake sets pin flag only
// - comparator wake sets comparator flag only
// - power-up sets both flags, clears wakes
// - flags hold until the next reset or sleep entry
// - pin flag compares against last port access
// - unread pin change wakes again at once
// - every wake clears the watchdog counter
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "wdsr_regs.svh"

module wdsr_watchdog #(
    parameter int unsigned BASE_TICKS = `WDSR_WDT_BASE_TICKS, // ticks in base period
    parameter int          BASE_W     = 15,                   // base counter width
    parameter int          PRE_W      = 7                     // prescaler width
) (
    // clock, reset and enable
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // register port
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // core strobes
    input  wire logic       clear_watchdog_instr,
    input  wire logic       sleep_instr,
    input  wire logic       port_access,
    // watchdog oscillator
    input  wire logic       wdt_osc_tick,
    // wake sources
    input  wire logic       port_pin_zero,
    input  wire logic       port_pin_one,
    input  wire logic       port_pin_three,
    input  wire logic       comparator_out,
    // external reset pin, open drain
    input  wire logic       ext_reset_pin_n,
    output logic            ext_reset_pin_o,
    output logic            ext_reset_pin_oe_n,
    // to the rest of the device
    output logic            device_reset,
    output logic            sleeping,
    output logic            io_hold
);

    // ****************************************************************
    // state
    // ****************************************************************
    localparam wdsr_pkg::wdsr_state_s RST_STATE = '{
        option:    `WDSR_OPTION_RST,
        cfg:       `WDSR_CONFIG_RST,
        mode:      wdsr_pkg::WDSR_AWAKE,
        to_n:      1'b1,
        pd_n:      1'b1,
        pin_wake:  1'b0,
        cmp_wake:  1'b0,
        dev_reset: 1'b0,
        rdata:     8'h00,
        ext_oe_n:  1'b1
    };

    wdsr_pkg::wdsr_state_s q;   // registered state
    wdsr_pkg::wdsr_state_s d;   // next state

    // ****************************************************************
    // events
    // ****************************************************************
    logic              asleep;      // core is in power-down
    logic              wdt_on;      // watchdog enabled by configuration
    logic              presc_wdt;   // prescaler belongs to the watchdog
    logic              ev_ext;      // external reset pin asserted
    logic              ev_wdt;      // watchdog time-out
    logic              ev_pin;      // pin change wake
    logic              ev_cmp;      // comparator change wake
    logic              ev_any;      // any device reset source
    logic              sleep_entry; // sleep accepted this cycle
    logic              wdt_clr;     // clear counter and prescaler
    logic              pre_clr;     // clear prescaler only
    logic              pre_inc;     // tick into prescaler
    logic              base_inc;    // tick into base counter
    logic              pre_done;    // prescaler wrapped
    logic              base_done;   // base counter wrapped
    logic [BASE_W-1:0] base_count;  // base counter value
    logic [7:0]        pre_term_w;  // 2**select - 1, one bit spare
    logic [PRE_W-1:0]  pre_term;    // prescaler terminal
    logic [BASE_W-1:0] base_term;   // base counter terminal
    logic              pin_changed; // wake pins differ from reference
    logic              cmp_changed; // comparator differs from reference

    assign asleep    = (q.mode == wdsr_pkg::WDSR_ASLEEP);
    assign wdt_on    = q.cfg[`WDSR_CFG_WDT_EN];
    assign presc_wdt = q.option[`WDSR_OPT_PRESC_ASSIGN];

    // reset pin acts only when configured as a reset input
    assign ev_ext = q.cfg[`WDSR_CFG_EXT_RST_EN] && !ext_reset_pin_n;
    assign ev_wdt = base_done;
    // pin and comparator wakes count only while asleep
    assign ev_pin = asleep && !q.option[`WDSR_OPT_PIN_WAKE_EN_N] && pin_changed;
    assign ev_cmp = asleep && q.cfg[`WDSR_CFG_CMP_WAKE_EN] && cmp_changed;
    assign ev_any = ev_ext || ev_wdt || ev_pin || ev_cmp;

    // a sleep that meets a reset event in the same cycle is dropped
    assign sleep_entry = sleep_instr && !asleep && !ev_any;

    // ****************************************************************
    // watchdog counting
    // ****************************************************************
    // disabled watchdog is held in clear so it can never wrap
    assign wdt_clr = !wdt_on
                  || ev_any
                  || sleep_entry
                  || (clear_watchdog_instr && !asleep);
    // prescaler handed to the timer restarts from zero when returned
    assign pre_clr  = wdt_clr || !presc_wdt;
    assign pre_inc  = wdt_osc_tick && presc_wdt;
    assign base_inc = presc_wdt ? pre_done : wdt_osc_tick;

    // ratio 1:1 gives a terminal of zero, i.e. a wrap on every tick
    assign pre_term_w = (8'h01 << q.option[`WDSR_OPT_PS_MSB:`WDSR_OPT_PS_LSB]) - 8'h01;
    assign pre_term   = pre_term_w[PRE_W-1:0];
    assign base_term  = BASE_W'(BASE_TICKS - 1);

    // prescaler, shared with the timer, used here only when assigned
    wdsr_tick_counter #(
        .W        (PRE_W)
    ) u_prescaler (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .clr      (pre_clr),
        .inc      (pre_inc),
        .terminal (pre_term),
        .done     (pre_done),
        .count    ()
    );

    // base period counter
    wdsr_tick_counter #(
        .W        (BASE_W)
    ) u_base (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .clr      (wdt_clr),
        .inc      (base_inc),
        .terminal (base_term),
        .done     (base_done),
        .count    (base_count)
    );

    // ****************************************************************
    // change detection
    // ****************************************************************
    // pins are referenced at the last port access; if software skips the
    // read before sleeping the old mismatch stays and wakes at once
    wdsr_change_det #(
        .W       (3)
    ) u_pin_chg (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .capture (port_access),
        .value   ({port_pin_three, port_pin_one, port_pin_zero}),
        .changed (pin_changed)
    );

    // comparator is referenced when sleep begins
    wdsr_change_det #(
        .W       (1)
    ) u_cmp_chg (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .capture (sleep_entry),
        .value   (comparator_out),
        .changed (cmp_changed)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    // reset events take priority: external pin, watchdog, pin, comparator
    always_comb begin
        d           = q;
        d.dev_reset = 1'b0;
        d.rdata     = 8'h00;
        d.ext_oe_n  = 1'b1;
        // register reads, data valid only in the next cycle
        if (rd) begin
            unique case (addr)
                `WDSR_OFF_STATUS: begin
                    d.rdata[`WDSR_ST_PIN_WAKE]    = q.pin_wake;
                    d.rdata[`WDSR_ST_CMP_WAKE]    = q.cmp_wake;
                    d.rdata[`WDSR_ST_TIMEOUT_N]   = q.to_n;
                    d.rdata[`WDSR_ST_POWERDOWN_N] = q.pd_n;
                end
                `WDSR_OFF_CONFIG: begin
                    d.rdata[2:0] = q.cfg;
                end
                default: begin
                    // option is write only, unmapped reads zero
                    d.rdata = 8'h00;
                end
            endcase
        end
        // register writes
        if (wr) begin
            if (addr == `WDSR_OFF_OPTION) begin
                d.option = wdata;
            end else if (addr == `WDSR_OFF_CONFIG) begin
                d.cfg = wdata[2:0];
            end
        end
        // flags change only on a reset event or sleep entry
        if (ev_ext) begin
            d.dev_reset = 1'b1;
            d.option    = `WDSR_OPTION_RST;
            d.mode      = wdsr_pkg::WDSR_AWAKE;
            d.pin_wake  = 1'b0;
            d.cmp_wake  = 1'b0;
            if (asleep) begin
                d.to_n = 1'b1;
                d.pd_n = 1'b0;
            end
        end else if (ev_wdt) begin
            d.dev_reset = 1'b1;
            d.option    = `WDSR_OPTION_RST;
            d.mode      = wdsr_pkg::WDSR_AWAKE;
            d.to_n      = 1'b0;
            d.pin_wake  = 1'b0;
            d.cmp_wake  = 1'b0;
            if (asleep) begin
                d.pd_n = 1'b0;
            end
        end else if (ev_pin) begin
            d.dev_reset = 1'b1;
            d.option    = `WDSR_OPTION_RST;
            d.mode      = wdsr_pkg::WDSR_AWAKE;
            d.pin_wake  = 1'b1;
            d.cmp_wake  = 1'b0;
            d.to_n      = 1'b1;
            d.pd_n      = 1'b0;
        end else if (ev_cmp) begin
            d.dev_reset = 1'b1;
            d.option    = `WDSR_OPTION_RST;
            d.mode      = wdsr_pkg::WDSR_AWAKE;
            d.cmp_wake  = 1'b1;
            d.pin_wake  = 1'b0;
            d.to_n      = 1'b1;
            d.pd_n      = 1'b0;
        end else if (sleep_entry) begin
            d.mode = wdsr_pkg::WDSR_ASLEEP;
            d.to_n = 1'b1;
            d.pd_n = 1'b0;
        end
        // otherwise flags stay as they are
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // power-up is the only asynchronous reset; it sets both flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

    // every output is a flip-flop of the state, except ext_reset_pin_o, which is tied low
    assign rdata              = q.rdata;
    assign device_reset       = q.dev_reset;
    assign sleeping           = asleep;
    assign io_hold            = asleep;
    assign ext_reset_pin_o    = 1'b0;
    assign ext_reset_pin_oe_n = q.ext_oe_n;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_wdt_off_silent: assert property (
        ce && !wdt_on |=> !ev_wdt) else $error("disabled watchdog timed out");
    a_timeout_resets: assert property (
        ce && ev_wdt |=> device_reset) else $error("time-out gave no device reset");
    a_timeout_flag: assert property (
        ce && ev_wdt && !ev_ext |=> !q.to_n) else $error("time-out flag not cleared");
    a_sleep_entry_flags: assert property (
        ce && sleep_entry |=> q.to_n && !q.pd_n && sleeping)
        else $error("sleep entry flags wrong");
    a_io_hold_cause: assert property (
        $rose(io_hold) |-> $past(sleep_entry)) else $error("hold without sleep entry");
    a_pin_never_driven: assert property (
        ext_reset_pin_oe_n && !ext_reset_pin_o) else $error("reset pin driven");
    a_wdt_wake_flags: assert property (
        ce && asleep && ev_wdt && !ev_ext
        |=> !q.to_n && !q.pd_n && !q.pin_wake && !q.cmp_wake && !sleeping)
        else $error("watchdog wake flags wrong");
    a_ext_awake_keeps: assert property (
        ce && ev_ext && !asleep
        |=> q.to_n == $past(q.to_n) && q.pd_n == $past(q.pd_n) && !q.pin_wake)
        else $error("external reset changed flags");
    a_pin_wake_flags: assert property (
        ce && ev_pin && !ev_ext && !ev_wdt
        |=> q.pin_wake && !q.cmp_wake && q.to_n && !q.pd_n && device_reset)
        else $error("pin wake flags wrong");
    a_cmp_wake_flags: assert property (
        ce && ev_cmp && !ev_pin && !ev_ext && !ev_wdt
        |=> q.cmp_wake && !q.pin_wake && q.to_n && !q.pd_n)
        else $error("comparator wake flags wrong");
    a_wake_clears_wdt: assert property (
        ce && asleep && ev_any |=> base_count == '0) else $error("wake left count");
    a_flags_hold: assert property (
        ce && !ev_any && !sleep_entry |=> $stable(q.to_n) && $stable(q.pin_wake))
        else $error("flag moved without cause");

    c_wdt_wake: cover property (ce && asleep && ev_wdt);
    c_pin_wake: cover property (ce && ev_pin);
    c_cmp_wake: cover property (ce && ev_cmp);
    c_ext_wake: cover property (ce && asleep && ev_ext);

endmodule

`default_nettype wire

// *** wdsr_core_model.sv ***
// core model: watchdog oscillator ticks and the sleep instruction strobe
// assumes: one clock mclk; the bench asks for sleep with a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module wdsr_core_model #(
    parameter int DIV = 4 // mclk cycles per oscillator tick
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // request from the bench
    input  wire logic req_sleep,
    // strobes to the block
    output logic      port_access,
    output logic      sleep_instr,
    output logic      wdt_osc_tick
);
    int cnt; // tick divider
    // free-running oscillator, keeps ticking while the core sleeps
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            wdt_osc_tick <= 1'b0;
        end else begin
            cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
            wdt_osc_tick <= (cnt == DIV - 1);
        end
    end
    // read the pins right before sleeping so the wake reference is fresh
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_access <= 1'b0;
            sleep_instr <= 1'b0;
        end else begin
            port_access <= req_sleep;
            sleep_instr <= port_access;
        end
    end
endmodule
`default_nettype wire

// *** wdsr_watchdog_tb_top.sv ***
// bench: register, wake and time-out scenarios for the watchdog block
// assumes: BASE_TICKS set to 8 and one tick every 4 cycles (32 cycles)
`timescale 1ns/1ps
`default_nettype none
module wdsr_watchdog_tb_top;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       clr = 1'b0;
    logic       req = 1'b0;
    logic [2:0] pin = 3'h0;
    logic       cmp = 1'b0;
    logic       ext_n = 1'b1;
    logic [7:0] rdata;
    logic       pa, sl, tick, pin_o, oe_n, dres, slp, hold;
    int         n_errors = 0;
    int         checks = 0;
    int         ndr = 0; // device resets seen
    int         n;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) if (dres === 1'b1) ndr++;
    wdsr_core_model #(.DIV(4)) wdsr_core_model_inst (.mclk(mclk), .rst_n(rst_n),
        .req_sleep(req), .port_access(pa), .sleep_instr(sl), .wdt_osc_tick(tick));
    wdsr_watchdog #(.BASE_TICKS(8)) wdsr_watchdog_inst (.mclk(mclk), .rst_n(rst_n),
        .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .clear_watchdog_instr(clr), .sleep_instr(sl), .port_access(pa),
        .wdt_osc_tick(tick), .port_pin_zero(pin[0]), .port_pin_one(pin[1]),
        .port_pin_three(pin[2]), .comparator_out(cmp), .ext_reset_pin_n(ext_n),
        .ext_reset_pin_o(pin_o), .ext_reset_pin_oe_n(oe_n), .device_reset(dres),
        .sleeping(slp), .io_hold(hold));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 check(rdata, exp);
        @(posedge mclk);
    endtask
    // one-cycle strobe: sel_req high pulses the sleep request, low the clear
    task automatic pulse(input bit sel_req);
        if (sel_req) begin
            req <= 1'b1;
        end else begin
            clr <= 1'b1;
        end
        @(posedge mclk);
        req <= 1'b0;
        clr <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    // cycles until the device reset pulse, bounded
    task automatic wait_rst(input int lim);
        n = 0;
        while (dres !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1 n++;
        end
        check(8'(n < lim), 8'h01);
        @(posedge mclk);
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rchk(2'h1, 8'h18);
        rchk(2'h0, 8'h00);
        rchk(2'h2, 8'h03);
        rchk(2'h3, 8'h00);
        wreg(2'h1, 8'hFF);
        rchk(2'h1, 8'h18);
        wreg(2'h0, 8'h07);
        pulse(1'b0);
        wait_rst(400);
        check(8'(n >= 24 && n <= 40), 8'h01);
        rchk(2'h1, 8'h08);
        check(8'({pin_o, oe_n}), 8'h01);
        wreg(2'h0, 8'h09);
        pulse(1'b0);
        wait_rst(400);
        check(8'(n >= 56 && n <= 72), 8'h01);
        wreg(2'h0, 8'h07);
        n = ndr;
        repeat (10) begin
            pulse(1'b0);
            repeat (16) @(posedge mclk);
        end
        check(8'(ndr - n), 8'h00);
        pulse(1'b1);
        check(8'({slp, hold}), 8'h03);
        rchk(2'h1, 8'h10);
        wait_rst(60);
        check(8'(n >= 20 && n <= 40), 8'h01);
        rchk(2'h1, 8'h00);
        check(8'(slp), 8'h00);
        wreg(2'h0, 8'h07);
        pulse(1'b1);
        pin[0] <= 1'b1;
        wait_rst(10);
        rchk(2'h1, 8'h90);
        wreg(2'h2, 8'h07);
        wreg(2'h0, 8'h87);
        pulse(1'b1);
        pin[0] <= 1'b0;
        cmp <= 1'b1;
        wait_rst(10);
        rchk(2'h1, 8'h50);
        wreg(2'h0, 8'h87);
        pulse(1'b1);
        ext_n <= 1'b0;
        wait_rst(10);
        ext_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rchk(2'h1, 8'h10);
        check(8'(slp), 8'h00);
        // short unscaled period, so a live watchdog would fire within the window
        wreg(2'h0, 8'h07);
        wreg(2'h2, 8'h06);
        n = ndr;
        pulse(1'b0);
        repeat (300) @(posedge mclk);
        check(8'(ndr - n), 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
